// ===== mwi_core.sv
// motion wake interrupt core: registers, wake-on-motion compare, status flags and pins
`timescale 1ns/1ns
`default_nettype none
module mwi_core #(
  parameter int SAMPLE_W = 16
) (
  input  wire logic                REF_CLK_I,
  input  wire logic                RST_N_I,
  input  wire logic                REG_WR_I,
  input  wire logic                REG_RD_I,
  input  wire logic [6:0]          REG_ADDR_I,
  input  wire logic [7:0]          REG_WDATA_I,
  output logic      [7:0]          REG_RDATA_O,
  input  wire logic                SAMPLE_VALID_I,
  input  wire logic [SAMPLE_W-1:0] HP_X_I,
  input  wire logic [SAMPLE_W-1:0] HP_Y_I,
  input  wire logic [SAMPLE_W-1:0] HP_Z_I,
  input  wire logic                CLOCK_LOCK_I,
  input  wire logic                DATA_READY_I,
  input  wire logic                FIFO_AT_WATERMARK_I,
  input  wire logic                FIFO_OVERFLOW_I,
  output logic                     IRQ_O,
  output logic                     IRQ_OE_O,
  output logic                     READY_FLAG_PIN_O,
  output logic                     READY_FLAG_PIN_OE_O,
  output logic [7:0]               RATE_DIVIDER_O,
  output logic [2:0]               POWER_MODE_O
);
  // refuse sample widths that the threshold scaling cannot serve
  if (SAMPLE_W < 9 || SAMPLE_W > 32) begin : g_bad_width
    $error("SAMPLE_W out of range");
  end

  // absolute value of a signed sample, saturating the most negative code
  function automatic logic [SAMPLE_W-1:0] abs_val(input logic [SAMPLE_W-1:0] s);
    logic [SAMPLE_W-1:0] r;
    r = s[SAMPLE_W-1] ? (~s + {{(SAMPLE_W-1){1'b0}}, 1'b1}) : s;
    if (r[SAMPLE_W-1]) r = {1'b0, {(SAMPLE_W-1){1'b1}}};
    return r;
  endfunction

  // threshold: 8-bit code scaled to sample magnitude (4 mg steps near upper bits)
  function automatic logic motion_hit(input logic [SAMPLE_W-1:0] s, input logic [7:0] thr);
    logic [SAMPLE_W+7:0] mag;
    logic [SAMPLE_W+7:0] lim;
    mag = {8'h00, abs_val(s)};
    lim = {{SAMPLE_W{1'b0}}, thr} << (SAMPLE_W - 9);
    return mag > lim;
  endfunction

  // register state
  logic [7:0] rate_div_q, rate_div_d;
  logic [7:0] filt_q, filt_d;
  logic [7:0] thr_q [3];
  logic [7:0] thr_d [3];
  logic [7:0] pin_cfg_q, pin_cfg_d;
  logic [7:0] src_en_q, src_en_d;
  logic [7:0] status_q, status_d;
  logic [7:0] mot_ctl_q, mot_ctl_d;
  logic [7:0] pwr1_q, pwr1_d;
  logic [7:0] pwr2_q, pwr2_d;
  logic [8:0] pulse_cnt_q, pulse_cnt_d;
  logic       prev_lock_q, prev_lock_d, prev_wm_q, prev_wm_d, prev_ovf_q, prev_ovf_d;
  logic [7:0] rdata_q, rdata_d;

  logic [2:0] axis_en, axis_hit;
  logic       motion_event, motion_active;
  logic [7:0] events;
  logic       any_pending, pin_level;
  logic [SAMPLE_W-1:0] samples [3];

  assign samples[0] = HP_X_I;
  assign samples[1] = HP_Y_I;
  assign samples[2] = HP_Z_I;
  assign axis_en = {src_en_q[mwi_pkg::BIT_MOTION_Z], src_en_q[mwi_pkg::BIT_MOTION_Y],
                    src_en_q[mwi_pkg::BIT_MOTION_X]};

  // per-axis compare, each axis against its own threshold
  for (genvar a = 0; a < 3; a++) begin : g_axis
    assign axis_hit[a] = motion_hit(samples[a], thr_q[a]);
  end

  // motion gating and axis combine
  always_comb begin
    motion_active = mot_ctl_q[mwi_pkg::BIT_MOTION_LOGIC_ON] &
                    mot_ctl_q[mwi_pkg::BIT_MOTION_COMPARE_SEL];
    motion_event = 1'b0;
    if (motion_active && SAMPLE_VALID_I && (axis_en != 3'b000)) begin
      if (mot_ctl_q[mwi_pkg::BIT_MOTION_COMBINE_SEL]) begin
        motion_event = ((axis_hit & axis_en) == axis_en);
      end else begin
        motion_event = |(axis_hit & axis_en);
      end
    end
  end

  // raw source events, motion reported on the enabled axis bits that hit
  always_comb begin
    events = 8'h00;
    events[mwi_pkg::BIT_MOTION_X]   = motion_event & axis_hit[0] & axis_en[0];
    events[mwi_pkg::BIT_MOTION_Y]   = motion_event & axis_hit[1] & axis_en[1];
    events[mwi_pkg::BIT_MOTION_Z]   = motion_event & axis_hit[2] & axis_en[2];
    events[mwi_pkg::BIT_OVERFLOW]   = FIFO_OVERFLOW_I & ~prev_ovf_q;
    events[mwi_pkg::BIT_WATERMARK]  = FIFO_AT_WATERMARK_I & ~prev_wm_q;
    events[mwi_pkg::BIT_CLOCK_LOCK] = CLOCK_LOCK_I & ~prev_lock_q;
    events[mwi_pkg::BIT_DATA_READY] = DATA_READY_I | (FIFO_AT_WATERMARK_I & ~prev_wm_q);
  end

  // register writes, status set and clear, read data
  always_comb begin
    logic status_rd, clr_all;
    status_rd    = REG_RD_I && (REG_ADDR_I == mwi_pkg::ADDR_IRQ_STATUS);
    clr_all      = pin_cfg_q[mwi_pkg::BIT_CLEAR_ANY_READ] ? REG_RD_I : status_rd;
    rate_div_d   = rate_div_q;
    filt_d       = filt_q;
    thr_d        = thr_q;
    pin_cfg_d    = pin_cfg_q;
    src_en_d     = src_en_q;
    mot_ctl_d    = mot_ctl_q;
    pwr1_d       = pwr1_q;
    pwr2_d       = pwr2_q;
    prev_lock_d  = CLOCK_LOCK_I;
    prev_wm_d    = FIFO_AT_WATERMARK_I;
    prev_ovf_d   = FIFO_OVERFLOW_I;
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        mwi_pkg::ADDR_SAMPLE_RATE_DIVIDER:   rate_div_d = REG_WDATA_I;
        mwi_pkg::ADDR_ACCEL_FILTER_SETUP:    filt_d     = REG_WDATA_I;
        mwi_pkg::ADDR_MOTION_THRESHOLD_X:    thr_d[0]   = REG_WDATA_I;
        mwi_pkg::ADDR_MOTION_THRESHOLD_Y:    thr_d[1]   = REG_WDATA_I;
        mwi_pkg::ADDR_MOTION_THRESHOLD_Z:    thr_d[2]   = REG_WDATA_I;
        mwi_pkg::ADDR_IRQ_PIN_CONFIG:        pin_cfg_d  = REG_WDATA_I;
        mwi_pkg::ADDR_IRQ_SOURCE_ENABLE:     src_en_d   = REG_WDATA_I;
        mwi_pkg::ADDR_MOTION_LOGIC_CONTROL:  mot_ctl_d  = REG_WDATA_I;
        mwi_pkg::ADDR_POWER_CONTROL_PRIMARY: pwr1_d     = REG_WDATA_I;
        mwi_pkg::ADDR_AXIS_STANDBY_CONTROL:  pwr2_d     = REG_WDATA_I;
        default: ;
      endcase
    end
    // enabled events set flags; set wins over a clearing read
    status_d = (clr_all ? 8'h00 : status_q) | (events & src_en_q);
    rdata_d = rdata_q;
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        mwi_pkg::ADDR_SAMPLE_RATE_DIVIDER:   rdata_d = rate_div_q;
        mwi_pkg::ADDR_ACCEL_FILTER_SETUP:    rdata_d = filt_q;
        mwi_pkg::ADDR_MOTION_THRESHOLD_X:    rdata_d = thr_q[0];
        mwi_pkg::ADDR_MOTION_THRESHOLD_Y:    rdata_d = thr_q[1];
        mwi_pkg::ADDR_MOTION_THRESHOLD_Z:    rdata_d = thr_q[2];
        mwi_pkg::ADDR_IRQ_PIN_CONFIG:        rdata_d = pin_cfg_q;
        mwi_pkg::ADDR_IRQ_SOURCE_ENABLE:     rdata_d = src_en_q;
        mwi_pkg::ADDR_IRQ_STATUS:            rdata_d = status_q;
        mwi_pkg::ADDR_MOTION_LOGIC_CONTROL:  rdata_d = mot_ctl_q;
        mwi_pkg::ADDR_POWER_CONTROL_PRIMARY: rdata_d = pwr1_q;
        mwi_pkg::ADDR_AXIS_STANDBY_CONTROL:  rdata_d = pwr2_q;
        default:                             rdata_d = 8'h00;
      endcase
    end
  end

  // pin pulse timer for non-latched operation
  always_comb begin
    pulse_cnt_d = pulse_cnt_q;
    if ((events & src_en_q) != 8'h00) begin
      pulse_cnt_d = 9'(mwi_pkg::PULSE_CYCLES);
    end else if (pulse_cnt_q != 9'h000) begin
      pulse_cnt_d = pulse_cnt_q - 9'h001;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rate_div_q  <= mwi_pkg::RST_ZERO;
      filt_q      <= mwi_pkg::RST_ZERO;
      thr_q       <= '{default: mwi_pkg::RST_ZERO};
      pin_cfg_q   <= mwi_pkg::RST_ZERO;
      src_en_q    <= mwi_pkg::RST_ZERO;
      status_q    <= mwi_pkg::RST_ZERO;
      mot_ctl_q   <= mwi_pkg::RST_ZERO;
      pwr1_q      <= mwi_pkg::RST_POWER_CONTROL_PRIMARY;
      pwr2_q      <= mwi_pkg::RST_ZERO;
      pulse_cnt_q <= 9'h000;
      prev_lock_q <= 1'b0;
      prev_wm_q   <= 1'b0;
      prev_ovf_q  <= 1'b0;
      rdata_q     <= 8'h00;
    end else begin
      rate_div_q  <= rate_div_d;
      filt_q      <= filt_d;
      thr_q       <= thr_d;
      pin_cfg_q   <= pin_cfg_d;
      src_en_q    <= src_en_d;
      status_q    <= status_d;
      mot_ctl_q   <= mot_ctl_d;
      pwr1_q      <= pwr1_d;
      pwr2_q      <= pwr2_d;
      pulse_cnt_q <= pulse_cnt_d;
      prev_lock_q <= prev_lock_d;
      prev_wm_q   <= prev_wm_d;
      prev_ovf_q  <= prev_ovf_d;
      rdata_q     <= rdata_d;
    end
  end

  // pin drive: latched level or timed pulse, polarity and drive type
  always_comb begin
    any_pending = pin_cfg_q[mwi_pkg::BIT_PIN_LATCH] ? (status_q != 8'h00)
                                                    : (pulse_cnt_q != 9'h000);
    pin_level   = any_pending ^ pin_cfg_q[mwi_pkg::BIT_PIN_ACT_LOW];
    IRQ_O       = pin_level;
    IRQ_OE_O    = pin_cfg_q[mwi_pkg::BIT_PIN_OPEN_DRAIN] ? ~pin_level : 1'b1;
    READY_FLAG_PIN_O    = pin_level;
    READY_FLAG_PIN_OE_O = IRQ_OE_O;
  end

  // power mode decode from sleep, cycle and standby bits
  always_comb begin
    logic acc_on, gyr_on, cyc;
    acc_on = ~&{pwr2_q[mwi_pkg::BIT_ACCEL_X_IDLE], pwr2_q[mwi_pkg::BIT_ACCEL_Y_IDLE],
                pwr2_q[mwi_pkg::BIT_ACCEL_Z_IDLE]};
    gyr_on = ~&{pwr2_q[mwi_pkg::BIT_RATE_X_IDLE], pwr2_q[mwi_pkg::BIT_RATE_Y_IDLE],
                pwr2_q[mwi_pkg::BIT_RATE_Z_IDLE]};
    cyc    = pwr1_q[mwi_pkg::BIT_DUTY_CYCLE_SELECT];
    if (pwr1_q[mwi_pkg::BIT_SLEEP] || (!acc_on && !gyr_on)) begin
      POWER_MODE_O = 3'(mwi_pkg::MWI_SLEEP);
    end else if (pwr1_q[mwi_pkg::BIT_ROTATION_IDLE] && !acc_on) begin
      POWER_MODE_O = 3'(mwi_pkg::MWI_STANDBY);
    end else if (acc_on && !gyr_on) begin
      POWER_MODE_O = cyc ? 3'(mwi_pkg::MWI_ACC_LP) : 3'(mwi_pkg::MWI_ACC_LN);
    end else if (!acc_on) begin
      POWER_MODE_O = cyc ? 3'(mwi_pkg::MWI_GYR_LP) : 3'(mwi_pkg::MWI_GYR_LN);
    end else begin
      POWER_MODE_O = cyc ? 3'(mwi_pkg::MWI_SIX_LP) : 3'(mwi_pkg::MWI_SIX_LN);
    end
  end

  assign REG_RDATA_O    = rdata_q;
  assign RATE_DIVIDER_O = rate_div_q;

  // status bit for motion follows a qualifying sample within one cycle
  chk_motion_sets_flag: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (motion_event && axis_hit[0] && axis_en[0] && src_en_q[mwi_pkg::BIT_MOTION_X])
      |=> status_q[mwi_pkg::BIT_MOTION_X]) else $error("motion x flag not set");
  chk_motion_gated_off: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    !motion_active |-> !motion_event) else $error("motion event while logic off");
  chk_and_combine: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (motion_event && mot_ctl_q[mwi_pkg::BIT_MOTION_COMBINE_SEL]) |-> ((axis_hit & axis_en) == axis_en))
    else $error("and combine fired without all axes");
  chk_disabled_no_flag: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (!src_en_q[mwi_pkg::BIT_OVERFLOW] && !status_q[mwi_pkg::BIT_OVERFLOW] && !REG_WR_I)
      |=> !status_q[mwi_pkg::BIT_OVERFLOW]) else $error("disabled source set flag");
  chk_pins_match: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    IRQ_O == READY_FLAG_PIN_O) else $error("pins disagree");
  chk_status_clear: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (REG_RD_I && REG_ADDR_I == mwi_pkg::ADDR_IRQ_STATUS && (events & src_en_q) == 8'h00)
      |=> status_q == 8'h00 ##0 rdata_q == $past(status_q)) else $error("status read did not clear");
  chk_latched_pin: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (pin_cfg_q[mwi_pkg::BIT_PIN_LATCH] && !pin_cfg_q[mwi_pkg::BIT_PIN_ACT_LOW] && status_q != 8'h00)
      |-> IRQ_O) else $error("latched pin not asserted");
  chk_watermark_ready: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (FIFO_AT_WATERMARK_I && !prev_wm_q && src_en_q[mwi_pkg::BIT_DATA_READY])
      |=> status_q[mwi_pkg::BIT_DATA_READY]) else $error("watermark did not raise data ready");
  chk_sample_paced: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    !SAMPLE_VALID_I |-> !motion_event) else $error("motion compared without sample");
  // or combine fires on any enabled hitting axis
  chk_or_combine: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (motion_active && SAMPLE_VALID_I && !mot_ctl_q[mwi_pkg::BIT_MOTION_COMBINE_SEL]
      && ((axis_hit & axis_en) != 3'b000)) |-> motion_event) else $error("or combine missed an axis");
  // flags only change on an enabled event or a read
  chk_status_holds: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (!REG_RD_I && ((events & src_en_q) == 8'h00))
      |=> $stable(status_q)) else $error("status changed without cause");
  // an enable write lands in the next cycle
  chk_enable_write: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    (REG_WR_I && (REG_ADDR_I == mwi_pkg::ADDR_IRQ_SOURCE_ENABLE))
      |=> (src_en_q == $past(REG_WDATA_I))) else $error("enable write lost");
  // pulse timer counts down one step per idle cycle
  chk_pulse_count: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    ((pulse_cnt_q != 9'h000) && ((events & src_en_q) == 8'h00))
      |=> (pulse_cnt_q == $past(pulse_cnt_q) - 9'h001)) else $error("pulse timer skipped");
  // sleep bit forces the sleep mode
  chk_sleep_mode: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
    pwr1_q[mwi_pkg::BIT_SLEEP] |-> (POWER_MODE_O == 3'(mwi_pkg::MWI_SLEEP))) else $error("sleep bit ignored");
endmodule
`default_nettype wire

// ===== mwi_pkg.sv
// package: register map, field positions and reset values of the motion wake interrupt block
package mwi_pkg;
  // register byte addresses
  localparam logic [6:0] ADDR_SAMPLE_RATE_DIVIDER  = 7'h19;
  localparam logic [6:0] ADDR_ACCEL_FILTER_SETUP   = 7'h1d;
  localparam logic [6:0] ADDR_MOTION_THRESHOLD_X   = 7'h20;
  localparam logic [6:0] ADDR_MOTION_THRESHOLD_Y   = 7'h21;
  localparam logic [6:0] ADDR_MOTION_THRESHOLD_Z   = 7'h22;
  localparam logic [6:0] ADDR_IRQ_PIN_CONFIG       = 7'h37;
  localparam logic [6:0] ADDR_IRQ_SOURCE_ENABLE    = 7'h38;
  localparam logic [6:0] ADDR_IRQ_STATUS           = 7'h3a;
  localparam logic [6:0] ADDR_MOTION_LOGIC_CONTROL = 7'h69;
  localparam logic [6:0] ADDR_POWER_CONTROL_PRIMARY = 7'h6b;
  localparam logic [6:0] ADDR_AXIS_STANDBY_CONTROL = 7'h6c;
  // reset values
  localparam logic [7:0] RST_ZERO                  = 8'h00;
  localparam logic [7:0] RST_POWER_CONTROL_PRIMARY = 8'h40;
  // irq_source_enable / irq_status bit positions
  localparam int BIT_MOTION_Z    = 5;
  localparam int BIT_MOTION_Y    = 6;
  localparam int BIT_MOTION_X    = 7;
  localparam int BIT_OVERFLOW    = 4;
  localparam int BIT_WATERMARK   = 3;
  localparam int BIT_CLOCK_LOCK  = 2;
  localparam int BIT_DATA_READY  = 0;
  // irq_pin_config bit positions
  localparam int BIT_PIN_ACT_LOW    = 7;
  localparam int BIT_PIN_OPEN_DRAIN = 6;
  localparam int BIT_PIN_LATCH      = 5;
  localparam int BIT_CLEAR_ANY_READ = 4;
  // motion_logic_control bit positions
  localparam int BIT_MOTION_LOGIC_ON      = 7;
  localparam int BIT_MOTION_COMPARE_SEL   = 6;
  localparam int BIT_MOTION_COMBINE_SEL   = 0;
  // power_control_primary bit positions
  localparam int BIT_SLEEP             = 6;
  localparam int BIT_DUTY_CYCLE_SELECT = 5;
  localparam int BIT_ROTATION_IDLE     = 4;
  // axis_standby_control bit positions
  localparam int BIT_ACCEL_X_IDLE = 5;
  localparam int BIT_ACCEL_Y_IDLE = 4;
  localparam int BIT_ACCEL_Z_IDLE = 3;
  localparam int BIT_RATE_X_IDLE  = 2;
  localparam int BIT_RATE_Y_IDLE  = 1;
  localparam int BIT_RATE_Z_IDLE  = 0;
  // wake-up rate span in millihertz
  localparam int WAKE_RATE_MIN_MHZ = 3900;
  localparam int WAKE_RATE_MAX_MHZ = 500000;
  // pulse width of a non-latched pin in cycles (50 us at 10 MHz)
  localparam int PULSE_TIME_NS     = 50000;
  localparam int CLK_PERIOD_NS     = 100;
  localparam int PULSE_CYCLES      = PULSE_TIME_NS / CLK_PERIOD_NS;
  // the eight power modes
  typedef enum logic [2:0] {
    MWI_SLEEP, MWI_STANDBY, MWI_ACC_LP, MWI_ACC_LN,
    MWI_GYR_LP, MWI_GYR_LN, MWI_SIX_LN, MWI_SIX_LP
  } mwi_power_mode_t;
endpackage

// ===== mwi_host_model.sv
// host processor model: register access, wake setup sequence and pulled-up pin level
`timescale 1ns/1ns
`default_nettype none
module mwi_host_model #(
  parameter logic [7:0] FILTER_WOM = 8'h09  // bypass bit plus lowpass setting one
) (
  input  wire logic       clk_i,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic [6:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       irq_i,
  input  wire logic       irq_oe_i,
  output logic            irq_level_o
);
  // pull-up holds the request line high while nobody drives it
  assign irq_level_o = irq_oe_i ? irq_i : 1'b1;
  // bus idle at time zero
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 7'h00;
    reg_wdata_o = 8'h00;
  end
  // one write strobe, released lines show the inverse of the last value
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
  // one read strobe, data taken once the registered answer has settled
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
  endtask
  // wake accel, idle gyro and set the filter before motion setup
  task automatic prep();
    wr(mwi_pkg::ADDR_POWER_CONTROL_PRIMARY, 8'h00);
    wr(mwi_pkg::ADDR_AXIS_STANDBY_CONTROL, 8'h07);
    wr(mwi_pkg::ADDR_ACCEL_FILTER_SETUP, FILTER_WOM);
  endtask
  // enter duty-cycled accel mode once motion setup is done
  task automatic cycle_on();
    wr(mwi_pkg::ADDR_POWER_CONTROL_PRIMARY, 8'h20);
  endtask
endmodule
`default_nettype wire

// ===== test_motion_wake_interrupt.sv
// testbench: registers, motion compare, event flags and pins of the motion wake core
`timescale 1ns/1ns
`default_nettype none
module test_motion_wake_interrupt;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        smp_vld = 1'b0;
  logic [15:0] hp_x = 16'h0000, hp_y = 16'h0000, hp_z = 16'h0000;
  logic [3:0]  evt = 4'h0;  // clock lock, data ready, watermark, overflow
  logic        reg_wr, reg_rd, irq, irq_oe, rdy, rdy_oe, irq_lvl;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rate_div, st;
  logic [2:0]  pwr_mode;
  int          miscompares = 0;
  int          n_tests = 0;
  logic [6:0]  rw_regs [10] = '{7'h19, 7'h1d, 7'h20, 7'h21, 7'h22, 7'h37, 7'h38, 7'h69, 7'h6b, 7'h6c};
  logic [7:0]  evt_flags [4] = '{8'h04, 8'h01, 8'h09, 8'h10};

  // 10 MHz clock
  always #50 clk = ~clk;

  mwi_core #(.SAMPLE_W(16)) i_dut (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_ADDR_I(reg_addr),
    .REG_WDATA_I(reg_wdata), .REG_RDATA_O(reg_rdata), .SAMPLE_VALID_I(smp_vld), .HP_X_I(hp_x),
    .HP_Y_I(hp_y), .HP_Z_I(hp_z), .CLOCK_LOCK_I(evt[3]), .DATA_READY_I(evt[2]),
    .FIFO_AT_WATERMARK_I(evt[1]), .FIFO_OVERFLOW_I(evt[0]), .IRQ_O(irq), .IRQ_OE_O(irq_oe),
    .READY_FLAG_PIN_O(rdy), .READY_FLAG_PIN_OE_O(rdy_oe), .RATE_DIVIDER_O(rate_div), .POWER_MODE_O(pwr_mode));
  mwi_host_model i_host (
    .clk_i(clk), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
    .reg_rdata_i(reg_rdata), .irq_i(irq), .irq_oe_i(irq_oe), .irq_level_o(irq_lvl));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    i_host.rd(a, st);
    check({8'h00, st}, {8'h00, exp});
  endtask
  // one-cycle sample strobe, released samples inverted
  task automatic motion(input logic [7:0] en, ctl, input logic [15:0] x, y, z, input logic [7:0] exp);
    i_host.wr(mwi_pkg::ADDR_IRQ_SOURCE_ENABLE, en);
    i_host.wr(mwi_pkg::ADDR_MOTION_LOGIC_CONTROL, ctl);
    @(negedge clk);
    smp_vld = 1'b1;
    {hp_x, hp_y, hp_z} = {x, y, z};
    @(negedge clk);
    smp_vld = 1'b0;
    {hp_x, hp_y, hp_z} = ~{x, y, z};
    rd_chk(mwi_pkg::ADDR_IRQ_STATUS, exp);
  endtask
  // power and standby writes, then the decoded mode
  task automatic pm_chk(input logic [7:0] p1, p2, input logic [2:0] exp);
    i_host.wr(mwi_pkg::ADDR_POWER_CONTROL_PRIMARY, p1);
    i_host.wr(mwi_pkg::ADDR_AXIS_STANDBY_CONTROL, p2);
    check(pwr_mode, exp);
  endtask
  task automatic pulse(input logic [3:0] e);
    @(negedge clk);
    evt = e;
    @(negedge clk);
    evt = 4'h0;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    #(6000 * 100);
    miscompares++;
    summarize();
  end

  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    check(pwr_mode, mwi_pkg::MWI_SLEEP);
    foreach (rw_regs[i]) begin
      rd_chk(rw_regs[i], (rw_regs[i] == mwi_pkg::ADDR_POWER_CONTROL_PRIMARY) ?
             mwi_pkg::RST_POWER_CONTROL_PRIMARY : mwi_pkg::RST_ZERO);
      i_host.wr(rw_regs[i], 8'ha5);
      rd_chk(rw_regs[i], 8'ha5);
      i_host.wr(rw_regs[i], (rw_regs[i] == mwi_pkg::ADDR_POWER_CONTROL_PRIMARY) ?
                mwi_pkg::RST_POWER_CONTROL_PRIMARY : mwi_pkg::RST_ZERO);
    end
    i_host.wr(mwi_pkg::ADDR_IRQ_STATUS, 8'hff);
    rd_chk(mwi_pkg::ADDR_IRQ_STATUS, 8'h00);
    i_host.wr(7'h7f, 8'hff);
    rd_chk(7'h7f, 8'h00);
    i_host.wr(mwi_pkg::ADDR_SAMPLE_RATE_DIVIDER, 8'h27);
    check(rate_div, 8'h27);
    pm_chk(8'h00, 8'h38, mwi_pkg::MWI_GYR_LN);
    pm_chk(8'h20, 8'h38, mwi_pkg::MWI_GYR_LP);
    pm_chk(8'h10, 8'h38, mwi_pkg::MWI_STANDBY);
    pm_chk(8'h00, 8'h00, mwi_pkg::MWI_SIX_LN);
    pm_chk(8'h20, 8'h00, mwi_pkg::MWI_SIX_LP);
    pm_chk(8'h40, 8'h00, mwi_pkg::MWI_SLEEP);
    $display("test registers done");
    // thresholds scale by 128: x 0x800, y 0x1000, z 0x1800
    i_host.prep();
    check(pwr_mode, mwi_pkg::MWI_ACC_LN);
    i_host.wr(mwi_pkg::ADDR_IRQ_PIN_CONFIG, 8'h20);
    i_host.wr(mwi_pkg::ADDR_MOTION_THRESHOLD_X, 8'h10);
    i_host.wr(mwi_pkg::ADDR_MOTION_THRESHOLD_Y, 8'h20);
    i_host.wr(mwi_pkg::ADDR_MOTION_THRESHOLD_Z, 8'h30);
    motion(8'h80, 8'hc0, 16'h0800, 16'h7fff, 16'h7fff, 8'h00);
    motion(8'h80, 8'hc0, 16'hf7ff, 16'h0000, 16'h0000, 8'h80);
    motion(8'he0, 8'hc0, 16'h0900, 16'h0900, 16'h0900, 8'h80);
    motion(8'he0, 8'hc0, 16'h0000, 16'h0000, 16'he7ff, 8'h20);
    motion(8'h60, 8'hc1, 16'h7fff, 16'h1001, 16'h0000, 8'h00);
    motion(8'h60, 8'hc1, 16'h0000, 16'h1001, 16'h1801, 8'h60);
    motion(8'he0, 8'h81, 16'h7fff, 16'h7fff, 16'h7fff, 8'h00);
    motion(8'he0, 8'h40, 16'h7fff, 16'h7fff, 16'h7fff, 8'h00);
    i_host.cycle_on();
    check(pwr_mode, mwi_pkg::MWI_ACC_LP);
    motion(8'he0, 8'hc0, 16'h0900, 16'h0000, 16'h0000, 8'h80);
    $display("test motion done");
    i_host.wr(mwi_pkg::ADDR_IRQ_SOURCE_ENABLE, 8'h1d);
    for (int i = 0; i < 4; i++) begin
      pulse(4'h8 >> i);
      rd_chk(mwi_pkg::ADDR_IRQ_STATUS, evt_flags[i]);
    end
    i_host.wr(mwi_pkg::ADDR_IRQ_SOURCE_ENABLE, 8'h00);
    pulse(4'hf);
    rd_chk(mwi_pkg::ADDR_IRQ_STATUS, 8'h00);
    // latched push-pull pin, then open drain active low
    i_host.wr(mwi_pkg::ADDR_IRQ_SOURCE_ENABLE, 8'h01);
    pulse(4'h4);
    @(negedge clk);
    check({irq, irq_oe, rdy, rdy_oe}, 4'hf);
    rd_chk(mwi_pkg::ADDR_IRQ_STATUS, 8'h01);
    check({irq, rdy}, 2'b00);
    i_host.wr(mwi_pkg::ADDR_IRQ_PIN_CONFIG, 8'he0);
    check({irq_lvl, irq_oe}, 2'b10);
    pulse(4'h4);
    @(negedge clk);
    check(irq_lvl, 1'b0);
    rd_chk(mwi_pkg::ADDR_IRQ_STATUS, 8'h01);
    // pulse mode pin holds for the pulse width only
    i_host.wr(mwi_pkg::ADDR_IRQ_PIN_CONFIG, 8'h00);
    pulse(4'h4);
    repeat (400) @(negedge clk);
    check(irq, 1'b1);
    repeat (110) @(negedge clk);
    check(irq, 1'b0);
    // mid-run reset drops the pin, read data and registers
    i_host.wr(mwi_pkg::ADDR_IRQ_SOURCE_ENABLE, 8'h01);
    pulse(4'h4);
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    check({irq, irq_oe, reg_rdata}, {2'b01, 8'h00});
    check(pwr_mode, mwi_pkg::MWI_SLEEP);
    rst_n = 1'b1;
    rd_chk(mwi_pkg::ADDR_IRQ_STATUS, 8'h00);
    rd_chk(mwi_pkg::ADDR_IRQ_SOURCE_ENABLE, 8'h00);
    $display("test events and pins done");
    summarize();
  end
endmodule
`default_nettype wire
